/* File: inc/fcr_nv_if.sv */
// port bundle between the register core and its non-volatile store
`timescale 1ns/1ps
interface fcr_nv_if;
  logic we;
  logic [1:0] waddr;
  logic [7:0] wdata;
  logic [1:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* File: inc/fcr_pkg.sv */
// shared constants, encodings and state types of the function and read parameter register block
package fcr_pkg;

  // serial instruction codes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_FUNC = 8'h42;
  localparam logic [7:0] OP_READ_FUNC = 8'h48;
  localparam logic [7:0] OP_SET_RP_PERSIST = 8'h65;
  localparam logic [7:0] OP_SET_RP_WORKING_A = 8'hC0;
  localparam logic [7:0] OP_SET_RP_WORKING_B = 8'h63;
  localparam logic [7:0] OP_READ_RP = 8'h61;
  localparam logic [7:0] OP_SET_ERP_PERSIST = 8'h85;
  localparam logic [7:0] OP_SET_ERP_WORKING = 8'h83;
  localparam logic [7:0] OP_READ_ERP = 8'h81;

  // word addresses inside the non-volatile store
  localparam logic [1:0] NV_ADDR_RP = 2'h0;
  localparam logic [1:0] NV_ADDR_ERP = 2'h1;
  localparam logic [1:0] NV_ADDR_FR = 2'h2;

  // function register fields
  localparam int FR_RST_DIS_BIT = 0;
  localparam int FR_PROT_DIR_BIT = 1;
  localparam int FR_PROG_SUSP_BIT = 2;
  localparam int FR_ERASE_SUSP_BIT = 3;
  localparam int FR_LOCK_LSB = 4;
  localparam int FR_LOCK_MSB = 7;
  localparam logic [7:0] FR_OTP_MASK = 8'hF3;
  localparam logic [6:0] FR_RESET_UPPER = 7'h00;

  // read parameter fields
  localparam int RP_PIN_SEL_BIT = 7;
  localparam int RP_DUMMY_MSB = 6;
  localparam int RP_DUMMY_LSB = 3;
  localparam int RP_WRAP_BIT = 2;
  localparam int RP_BURST_MSB = 1;
  localparam int RP_BURST_LSB = 0;
  localparam logic [7:0] RP_RESET = 8'h00;
  localparam logic [7:0] ERP_RESET = 8'hFF;

  // default dummy counts used when the dummy field is zero
  localparam logic [3:0] DUMMY_DEF_FAST_SPI = 4'h8;
  localparam logic [3:0] DUMMY_DEF_FAST_QPI = 4'h6;
  localparam logic [3:0] DUMMY_DEF_DUAL_OUT = 4'h8;
  localparam logic [3:0] DUMMY_DEF_DUAL_IO = 4'h4;
  localparam logic [3:0] DUMMY_DEF_QUAD_OUT = 4'h8;
  localparam logic [3:0] DUMMY_DEF_QUAD_IO = 4'h6;

  // burst lengths in bytes
  localparam logic [6:0] BURST_8 = 7'h08;
  localparam logic [6:0] BURST_16 = 7'h10;
  localparam logic [6:0] BURST_32 = 7'h20;
  localparam logic [6:0] BURST_64 = 7'h40;

  typedef enum logic [2:0] {
    RK_FAST_SPI = 3'h0,
    RK_FAST_QPI = 3'h1,
    RK_DUAL_OUT = 3'h2,
    RK_DUAL_IO = 3'h3,
    RK_QUAD_OUT = 3'h4,
    RK_QUAD_IO = 3'h5
  } fcr_read_kind_t;

  typedef enum logic [2:0] {
    ST_LOAD_RP = 3'h0,
    ST_LOAD_ERP = 3'h1,
    ST_LOAD_FR = 3'h2,
    ST_LOAD_END = 3'h3,
    ST_RUN = 3'h4
  } fcr_state_t;

  typedef struct packed {
    logic [7:0] rp;
    logic [7:0] erp;
    logic [7:0] fr;
    logic [7:0] rdata;
  } fcr_nv_t;

  typedef struct packed {
    fcr_state_t st;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic sclk_prev;
    logic [2:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [7:0] shift_in;
    logic [7:0] opcode;
    logic [7:0] out_sh;
    logic so;
    logic so_oe;
    logic wel;
    logic [7:0] rp_vol;
    logic [7:0] erp_vol;
    logic [7:0] fr;
    logic nv_we;
    logic [1:0] nv_waddr;
    logic [7:0] nv_wdata;
    logic [3:0] dummy;
    logic [6:0] burst_bytes;
    logic wrap_en;
    logic pin_pause;
    logic pin_reset;
    logic pin_io3;
    logic ded_reset;
  } fcr_core_t;

endpackage

/* File: src/fcr_func_read_regs.sv */
// function register and read parameter registers of a serial flash, reached over the serial pins
`timescale 1ns/1ps
// Function
// [RULE1] one-time-programmable function bits, once one, never return to zero
// [RULE2] protection direction bit: zero top area, one bottom, sticky at bottom
// [RULE3] program-suspended flag sets on suspend during program, clears on resume
// [RULE4] erase-suspended flag sets on suspend during erase, clears on resume
// [RULE5] four sticky row lock bits; a set lock blocks programming its row
// [RULE6] dedicated reset pin active while disable bit zero; else shared pin
// [RULE7] read and extended read registers have persistent and working copies
// [RULE8] serial mode, quad off: pin-select zero pause, one reset; else data line
// [RULE9] dedicated reset variant, disable bit zero: shared pin always pause
// [RULE10] nonzero four-bit dummy field gives that many dummy cycles, 1 to 15
// [RULE11] burst field 00/01/10/11 gives 8/16/32/64 bytes
// [RULE12] wrap bit zero reads run whole array; one wraps at burst length
// [RULE13] 65h writes persistent copy, C0h or 63h working copy only
// [RULE14] read parameters reset to zero; function bits 7 to 1 default zero
// [RULE15] host sends write enable before persistent or function writes
// [RULE16] zero dummy field: 8 fast serial, 6 fast quad, 4 dual, 6 quad I/O; code gives 4 for dual I/O only, 8 for dual output
// [RULE17] writes to suspend flags ignored; zero over a stored one changes nothing
module fcr_func_read_regs #(
  parameter logic HAS_DEDICATED_RESET = 1'b1,
  parameter logic RESET_DISABLE_DEFAULT = 1'b0
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  output logic so_out,
  output logic so_oe_out,
  input wire logic quad_lines_enable_in,
  input wire logic qpi_mode_in,
  input wire logic program_busy_in,
  input wire logic erase_busy_in,
  input wire logic suspend_in,
  input wire logic resume_in,
  input wire fcr_pkg::fcr_read_kind_t read_kind_in,
  input wire logic ir_prog_req_in,
  input wire logic [1:0] ir_row_in,
  output logic ir_prog_allow_out,
  output logic ready_out,
  output logic [7:0] function_config_status_out,
  output logic [7:0] read_parameters_out,
  output logic [7:0] ext_read_params_out,
  output logic program_suspended_flag_out,
  output logic erase_suspended_flag_out,
  output logic protect_area_direction_out,
  output logic [3:0] info_row_lock_out,
  output logic dedicated_reset_active_out,
  output logic shared_pin_pause_out,
  output logic shared_pin_reset_out,
  output logic shared_pin_io3_out,
  output logic [3:0] dummy_cycles_out,
  output logic wrap_enable_out,
  output logic [6:0] burst_bytes_out
);
  fcr_nv_if nv ();

  fcr_pkg::fcr_core_t q;
  fcr_pkg::fcr_core_t n;

  fcr_nv_store #(
    .RESET_DISABLE_DEFAULT(RESET_DISABLE_DEFAULT)
  ) u_nv (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .nv(nv.store)
  );

  function automatic logic [3:0] fcr_default_dummy(input fcr_pkg::fcr_read_kind_t k);
    logic [3:0] d;
    unique case (k)
      fcr_pkg::RK_FAST_SPI: d = fcr_pkg::DUMMY_DEF_FAST_SPI;
      fcr_pkg::RK_FAST_QPI: d = fcr_pkg::DUMMY_DEF_FAST_QPI;
      fcr_pkg::RK_DUAL_OUT: d = fcr_pkg::DUMMY_DEF_DUAL_OUT;
      fcr_pkg::RK_DUAL_IO: d = fcr_pkg::DUMMY_DEF_DUAL_IO;
      fcr_pkg::RK_QUAD_OUT: d = fcr_pkg::DUMMY_DEF_QUAD_OUT;
      fcr_pkg::RK_QUAD_IO: d = fcr_pkg::DUMMY_DEF_QUAD_IO;
      default: d = fcr_pkg::DUMMY_DEF_FAST_SPI;
    endcase
    return d;
  endfunction

  // the store's read port follows the power-up load sequence
  assign nv.raddr = (q.st == fcr_pkg::ST_LOAD_ERP) ? fcr_pkg::NV_ADDR_ERP :
                    (q.st == fcr_pkg::ST_LOAD_FR) ? fcr_pkg::NV_ADDR_FR : fcr_pkg::NV_ADDR_RP;
  assign nv.we = q.nv_we;
  assign nv.waddr = q.nv_waddr;
  assign nv.wdata = q.nv_wdata;

  always_comb begin
    logic sclk;
    logic csn;
    logic sdi;
    logic rise;
    logic fall;
    logic quad;
    logic [7:0] sh;
    logic [7:0] op;
    logic [7:0] otp;
    logic [3:0] dfield;
    sclk = q.sync2[0];
    csn = q.sync2[1];
    sdi = q.sync2[2];
    rise = sclk & ~q.sclk_prev;
    fall = ~sclk & q.sclk_prev;
    quad = quad_lines_enable_in | qpi_mode_in;
    sh = {q.shift_in[6:0], sdi};
    op = (q.byte_cnt == 2'h0) ? sh : q.opcode;
    otp = (q.fr | sh) & fcr_pkg::FR_OTP_MASK;
    dfield = q.rp_vol[fcr_pkg::RP_DUMMY_MSB:fcr_pkg::RP_DUMMY_LSB];

    n = q;
    // the logic and the edge memory read only the second synchroniser stage
    n.sync1 = {si_in, cs_n_in, sclk_in};
    n.sync2 = q.sync1;
    n.sclk_prev = q.sync2[0];
    n.nv_we = 1'b0;

    unique case (q.st)
      fcr_pkg::ST_LOAD_RP: begin
        n.st = fcr_pkg::ST_LOAD_ERP;
      end
      fcr_pkg::ST_LOAD_ERP: begin
        n.rp_vol = nv.rdata; // see [RULE7]
        n.st = fcr_pkg::ST_LOAD_FR;
      end
      fcr_pkg::ST_LOAD_FR: begin
        n.erp_vol = nv.rdata; // see [RULE7]
        n.st = fcr_pkg::ST_LOAD_END;
      end
      fcr_pkg::ST_LOAD_END: begin
        n.fr = nv.rdata & fcr_pkg::FR_OTP_MASK;
        n.st = fcr_pkg::ST_RUN;
      end
      fcr_pkg::ST_RUN: begin
        if (csn) begin
          // deselect ends any instruction; a partial one has no effect
          n.bit_cnt = 3'h0;
          n.byte_cnt = 2'h0;
          n.so_oe = 1'b0;
          n.so = 1'b0;
        end else if (rise) begin
          n.shift_in = sh;
          n.bit_cnt = q.bit_cnt + 3'h1;
          if (q.bit_cnt == 3'h7) begin
            if (q.byte_cnt != 2'h2) begin
              n.byte_cnt = q.byte_cnt + 2'h1;
            end
            if (q.byte_cnt == 2'h0) begin
              n.opcode = sh;
              if (sh == fcr_pkg::OP_WRITE_ENABLE) begin
                n.wel = 1'b1;
              end
            end else if (q.byte_cnt == 2'h1) begin
              unique case (q.opcode)
                fcr_pkg::OP_SET_RP_WORKING_A, fcr_pkg::OP_SET_RP_WORKING_B: begin
                  n.rp_vol = sh; // see [RULE13]
                end
                fcr_pkg::OP_SET_ERP_WORKING: begin
                  n.erp_vol = sh;
                end
                fcr_pkg::OP_SET_RP_PERSIST, fcr_pkg::OP_SET_ERP_PERSIST: begin
                  if (q.wel) begin // see [RULE15]
                    n.nv_we = 1'b1; // see [RULE13]
                    n.nv_waddr = (q.opcode == fcr_pkg::OP_SET_RP_PERSIST) ? fcr_pkg::NV_ADDR_RP
                                                                        : fcr_pkg::NV_ADDR_ERP;
                    n.nv_wdata = sh;
                    n.wel = 1'b0;
                  end
                end
                fcr_pkg::OP_WRITE_FUNC: begin
                  if (q.wel) begin // see [RULE15]
                    // suspend flags kept from state, otp bits only ever gain ones; see [RULE17]
                    n.fr = otp | (q.fr & ~fcr_pkg::FR_OTP_MASK); // see [RULE1] [RULE2] [RULE5]
                    n.nv_we = 1'b1;
                    n.nv_waddr = fcr_pkg::NV_ADDR_FR;
                    n.nv_wdata = otp;
                    n.wel = 1'b0;
                  end
                end
                default: begin
                  n.nv_we = 1'b0;
                end
              endcase
            end
            // register reads repeat the value for as long as the clock keeps running
            unique case (op)
              fcr_pkg::OP_READ_FUNC: begin
                n.out_sh = q.fr;
                n.so_oe = 1'b1;
              end
              fcr_pkg::OP_READ_RP: begin
                n.out_sh = q.rp_vol;
                n.so_oe = 1'b1;
              end
              fcr_pkg::OP_READ_ERP: begin
                n.out_sh = q.erp_vol;
                n.so_oe = 1'b1;
              end
              default: begin
                n.so_oe = q.so_oe;
              end
            endcase
          end
        end else if (fall && q.so_oe) begin
          n.so = q.out_sh[7];
          n.out_sh = {q.out_sh[6:0], 1'b0};
        end
        // a resume clears first so that a suspend in the same cycle still sets
        if (resume_in) begin
          n.fr[fcr_pkg::FR_PROG_SUSP_BIT] = 1'b0; // see [RULE3]
          n.fr[fcr_pkg::FR_ERASE_SUSP_BIT] = 1'b0; // see [RULE4]
        end
        if (suspend_in && program_busy_in) begin
          n.fr[fcr_pkg::FR_PROG_SUSP_BIT] = 1'b1; // see [RULE3]
        end
        if (suspend_in && erase_busy_in) begin
          n.fr[fcr_pkg::FR_ERASE_SUSP_BIT] = 1'b1; // see [RULE4]
        end
      end
      default: begin
        n.st = fcr_pkg::ST_LOAD_RP;
      end
    endcase

    // decoded controls follow the working copies one cycle later
    n.ded_reset = HAS_DEDICATED_RESET & ~q.fr[fcr_pkg::FR_RST_DIS_BIT]; // see [RULE6]
    n.pin_io3 = quad; // see [RULE8]
    n.pin_reset = ~quad & q.rp_vol[fcr_pkg::RP_PIN_SEL_BIT] & ~n.ded_reset; // see [RULE8] [RULE9]
    n.pin_pause = ~quad & ~n.pin_reset; // see [RULE9]
    n.dummy = (dfield != 4'h0) ? dfield : fcr_default_dummy(read_kind_in); // see [RULE10] [RULE16]
    n.wrap_en = q.rp_vol[fcr_pkg::RP_WRAP_BIT]; // see [RULE12]
    unique case (q.rp_vol[fcr_pkg::RP_BURST_MSB:fcr_pkg::RP_BURST_LSB])
      2'h0: n.burst_bytes = fcr_pkg::BURST_8; // see [RULE11]
      2'h1: n.burst_bytes = fcr_pkg::BURST_16;
      2'h2: n.burst_bytes = fcr_pkg::BURST_32;
      2'h3: n.burst_bytes = fcr_pkg::BURST_64;
    endcase
  end

  // all-zero reset: load sequence start, working copies zero until loaded
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= n;
    end
  end

  assign so_out = q.so;
  assign so_oe_out = q.so_oe;
  assign ready_out = (q.st == fcr_pkg::ST_RUN);
  assign function_config_status_out = q.fr;
  assign read_parameters_out = q.rp_vol;
  assign ext_read_params_out = q.erp_vol;
  assign program_suspended_flag_out = q.fr[fcr_pkg::FR_PROG_SUSP_BIT];
  assign erase_suspended_flag_out = q.fr[fcr_pkg::FR_ERASE_SUSP_BIT];
  assign protect_area_direction_out = q.fr[fcr_pkg::FR_PROT_DIR_BIT]; // see [RULE2]
  assign info_row_lock_out = q.fr[fcr_pkg::FR_LOCK_MSB:fcr_pkg::FR_LOCK_LSB];
  // a set lock refuses programming of its row; see [RULE5]
  assign ir_prog_allow_out = ir_prog_req_in & ~info_row_lock_out[ir_row_in];
  assign dedicated_reset_active_out = q.ded_reset;
  assign shared_pin_pause_out = q.pin_pause;
  assign shared_pin_reset_out = q.pin_reset;
  assign shared_pin_io3_out = q.pin_io3;
  assign dummy_cycles_out = q.dummy;
  assign wrap_enable_out = q.wrap_en;
  assign burst_bytes_out = q.burst_bytes;
endmodule

/* File: src/fcr_nv_store.sv */
// non-volatile copies of the read parameters, extended read parameters and function register
`timescale 1ns/1ps
module fcr_nv_store #(
  parameter logic RESET_DISABLE_DEFAULT = 1'b0
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  fcr_nv_if.store nv
);
  fcr_pkg::fcr_nv_t q;
  fcr_pkg::fcr_nv_t n;

  always_comb begin
    n = q;
    if (nv.we) begin
      unique case (nv.waddr)
        fcr_pkg::NV_ADDR_RP: n.rp = nv.wdata;
        fcr_pkg::NV_ADDR_ERP: n.erp = nv.wdata;
        // stored ones are never cleared, whatever the core sends; see [RULE1]
        fcr_pkg::NV_ADDR_FR: n.fr = q.fr | (nv.wdata & fcr_pkg::FR_OTP_MASK);
        default: n = q;
      endcase
    end
    unique case (nv.raddr)
      fcr_pkg::NV_ADDR_RP: n.rdata = q.rp;
      fcr_pkg::NV_ADDR_ERP: n.rdata = q.erp;
      fcr_pkg::NV_ADDR_FR: n.rdata = q.fr;
      default: n.rdata = 8'h00;
    endcase
  end

  // the reset here stands for the factory state of the cells
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q.rp <= fcr_pkg::RP_RESET; // see [RULE14]
      q.erp <= fcr_pkg::ERP_RESET;
      q.fr <= {fcr_pkg::FR_RESET_UPPER, RESET_DISABLE_DEFAULT}; // see [RULE14]
      q.rdata <= 8'h00;
    end else if (ce_in) begin
      q <= n;
    end
  end

  assign nv.rdata = q.rdata;
endmodule

/* File: test/fcr_func_read_regs_props.sv */
// concurrent checks on the ports of the function and read parameter register block
`timescale 1ns/1ps
module fcr_func_read_regs_props #(
  parameter logic HAS_DEDICATED_RESET = 1'b1
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic quad_lines_enable_in,
  input wire logic qpi_mode_in,
  input wire logic program_busy_in,
  input wire logic erase_busy_in,
  input wire logic suspend_in,
  input wire logic resume_in,
  input wire fcr_pkg::fcr_read_kind_t read_kind_in,
  input wire logic ir_prog_req_in,
  input wire logic [1:0] ir_row_in,
  input wire logic ir_prog_allow_out,
  input wire logic ready_out,
  input wire logic [7:0] function_config_status_out,
  input wire logic [7:0] read_parameters_out,
  input wire logic program_suspended_flag_out,
  input wire logic erase_suspended_flag_out,
  input wire logic dedicated_reset_active_out,
  input wire logic shared_pin_pause_out,
  input wire logic shared_pin_io3_out,
  input wire logic [3:0] dummy_cycles_out,
  input wire logic wrap_enable_out,
  input wire logic [6:0] burst_bytes_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  function automatic logic [3:0] dflt(input fcr_pkg::fcr_read_kind_t k);
    case (k)
      fcr_pkg::RK_DUAL_IO: return 4'h4;
      fcr_pkg::RK_FAST_QPI, fcr_pkg::RK_QUAD_IO: return 4'h6;
      default: return 4'h8;
    endcase
  endfunction
  property p_allow;
    ir_prog_allow_out == (ir_prog_req_in && !function_config_status_out[4 + ir_row_in]);
  endproperty
  a_allow: assert property (p_allow)
    else $error("row program permission wrong");
  property p_otp;
    (function_config_status_out & $past(function_config_status_out) & 8'hF3) ==
      ($past(function_config_status_out) & 8'hF3);
  endproperty
  a_otp: assert property (p_otp)
    else $error("one-time bit went back to zero");
  property p_program_suspended_flag;
    ready_out && ce_in && suspend_in && program_busy_in |=> program_suspended_flag_out;
  endproperty
  a_program_suspended_flag: assert property (p_program_suspended_flag)
    else $error("program suspend flag not set");
  property p_erase_suspended_flag;
    ready_out && ce_in && suspend_in && erase_busy_in |=> erase_suspended_flag_out;
  endproperty
  a_erase_suspended_flag: assert property (p_erase_suspended_flag)
    else $error("erase suspend flag not set");
  property p_resume;
    ready_out && ce_in && resume_in && !suspend_in |=> !program_suspended_flag_out && !erase_suspended_flag_out;
  endproperty
  a_resume: assert property (p_resume)
    else $error("suspend flag not cleared on resume");
  property p_flag_cause;
    $rose(erase_suspended_flag_out) |-> $past(suspend_in) && $past(erase_busy_in);
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("erase flag rose without suspend");
  property p_burst;
    ready_out && ce_in |=> burst_bytes_out == (7'h08 << $past(read_parameters_out[1:0]));
  endproperty
  a_burst: assert property (p_burst)
    else $error("burst length decode wrong");
  property p_wrap;
    ready_out && ce_in |=> wrap_enable_out == $past(read_parameters_out[2]);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap enable wrong");
  property p_dummy;
    ready_out && ce_in |=> dummy_cycles_out == (($past(read_parameters_out[6:3]) != 4'h0) ?
      $past(read_parameters_out[6:3]) : dflt($past(read_kind_in)));
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("dummy count wrong");
  property p_io3;
    ready_out && ce_in |=> shared_pin_io3_out == ($past(quad_lines_enable_in) || $past(qpi_mode_in));
  endproperty
  a_io3: assert property (p_io3)
    else $error("shared pin data role wrong");
  property p_pause;
    ready_out && ce_in && !quad_lines_enable_in && !qpi_mode_in |=> shared_pin_pause_out ==
      (!$past(read_parameters_out[7]) || (HAS_DEDICATED_RESET && !$past(function_config_status_out[0])));
  endproperty
  a_pause: assert property (p_pause)
    else $error("shared pin pause role wrong");
  property p_ded;
    ready_out && ce_in |=> dedicated_reset_active_out ==
      (HAS_DEDICATED_RESET && !$past(function_config_status_out[0]));
  endproperty
  a_ded: assert property (p_ded)
    else $error("dedicated reset state wrong");
  property p_load;
    $rose(ready_out) |-> read_parameters_out == 8'h00;
  endproperty
  a_load: assert property (p_load)
    else $error("working read parameters not loaded");
endmodule
bind fcr_func_read_regs fcr_func_read_regs_props #(.HAS_DEDICATED_RESET(HAS_DEDICATED_RESET)) u_props (
  .core_clk_in, .resetn_in, .ce_in, .quad_lines_enable_in, .qpi_mode_in, .program_busy_in, .erase_busy_in,
  .suspend_in, .resume_in, .read_kind_in, .ir_prog_req_in, .ir_row_in, .ir_prog_allow_out, .ready_out,
  .function_config_status_out, .read_parameters_out, .program_suspended_flag_out, .erase_suspended_flag_out,
  .dedicated_reset_active_out, .shared_pin_pause_out, .shared_pin_io3_out, .dummy_cycles_out,
  .wrap_enable_out, .burst_bytes_out);

/* File: test/fcr_func_read_regs_tb.sv */
// self-checking bench for the function and read parameter register block
`timescale 1ns/1ps
module fcr_func_read_regs_tb;
  typedef enum logic [2:0] {S_FR, S_RP, S_DUM, S_BUR, S_WRAP, S_PIN, S_ALLOW, S_RD} fcr_sel_t;
  typedef struct packed {fcr_sel_t sel; logic [7:0] val;} fcr_note_t;
  logic core_clk_in = 1'b0, resetn_in = 1'b0, ce_in = 1'b1, sclk_in, cs_n_in, si_in, so_out, so_oe_out;
  logic quad_lines_enable_in = 1'b0, qpi_mode_in = 1'b0, program_busy_in = 1'b0, erase_busy_in = 1'b0;
  logic suspend_in = 1'b0, resume_in = 1'b0, ir_prog_req_in = 1'b0, ir_prog_allow_out, ready_out;
  logic [1:0] ir_row_in = 2'h0;
  fcr_pkg::fcr_read_kind_t read_kind_in = fcr_pkg::RK_FAST_SPI;
  logic [7:0] function_config_status_out, read_parameters_out, rd_q, d, seen, e;
  logic dedicated_reset_active_out, shared_pin_pause_out, shared_pin_reset_out, shared_pin_io3_out;
  logic [3:0] dummy_cycles_out, info_row_lock_out;
  logic protect_area_direction_out;
  logic [7:0] ext_read_params_out;
  logic wrap_enable_out;
  logic [6:0] burst_bytes_out;
  logic [3:0] dflt_tab [6] = '{4'h8, 4'h6, 4'h8, 4'h4, 4'h8, 4'h6};
  fcr_note_t notes[$];
  fcr_note_t note;
  int failures = 0, n_compared = 0, cycles = 0;
  int seed = 32'h549B0A0E;
  always #5 core_clk_in = ~core_clk_in;
  fcr_host_model host (.sclk_out(sclk_in), .cs_n_out(cs_n_in), .si_out(si_in), .so_in(so_out));
  fcr_func_read_regs dut (.core_clk_in, .resetn_in, .ce_in, .sclk_in, .cs_n_in, .si_in, .so_out, .so_oe_out,
    .quad_lines_enable_in, .qpi_mode_in, .program_busy_in, .erase_busy_in, .suspend_in, .resume_in,
    .read_kind_in, .ir_prog_req_in, .ir_row_in, .ir_prog_allow_out, .ready_out, .function_config_status_out,
    .read_parameters_out, .ext_read_params_out, .program_suspended_flag_out(), .erase_suspended_flag_out(),
    .protect_area_direction_out, .info_row_lock_out, .dedicated_reset_active_out, .shared_pin_pause_out,
    .shared_pin_reset_out, .shared_pin_io3_out, .dummy_cycles_out, .wrap_enable_out, .burst_bytes_out);
  task automatic check(input logic [7:0] s, input logic [7:0] x);
    n_compared++;
    if (s !== x) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic give_verdict;
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic expect_v(input fcr_sel_t s, input logic [7:0] v);
    notes.push_back('{s, v});
    repeat (2) @(negedge core_clk_in);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] v);
    host.xfer(op, v, 1'b1, rd_q);
  endtask
  task automatic write_enable_cmd;
    host.xfer(fcr_pkg::OP_WRITE_ENABLE, 8'h00, 1'b0, rd_q);
  endtask
  task automatic do_reset;
    repeat (10) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    expect_v(S_FR, 8'h00);
    expect_v(S_RP, 8'h00);
    expect_v(S_BUR, 8'h08);
    expect_v(S_PIN, 8'h0C);
    check(ext_read_params_out, fcr_pkg::ERP_RESET);
  endtask
  // results are compared on the falling edge, when every registered output has settled
  always @(negedge core_clk_in) begin
    while (notes.size() != 0) begin
      note = notes.pop_front();
      case (note.sel)
        S_FR: seen = function_config_status_out;
        S_RP: seen = read_parameters_out;
        S_DUM: seen = {4'h0, dummy_cycles_out};
        S_BUR: seen = {1'b0, burst_bytes_out};
        S_WRAP: seen = {7'h00, wrap_enable_out};
        S_PIN: seen = {4'h0, dedicated_reset_active_out, shared_pin_pause_out,
          shared_pin_reset_out, shared_pin_io3_out};
        S_ALLOW: seen = {7'h00, ir_prog_allow_out};
        default: seen = rd_q;
      endcase
      check(seen, note.val);
    end
  end
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    do_reset();
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      d[1:0] = i[1:0];
      if (i == 3) d[6:3] = 4'hF;
      if (i == 4) d[6:3] = 4'h1;
      if (i == 5) d[6:3] = 4'h0;
      cmd(i[0] ? fcr_pkg::OP_SET_RP_WORKING_B : fcr_pkg::OP_SET_RP_WORKING_A, d);
      expect_v(S_RP, d);
      expect_v(S_BUR, {1'b0, 7'h08 << i[1:0]});
      expect_v(S_WRAP, {7'h00, d[2]});
      expect_v(S_DUM, {4'h0, (d[6:3] != 4'h0) ? d[6:3] : dflt_tab[read_kind_in]});
      expect_v(S_PIN, 8'h0C);
      cmd(fcr_pkg::OP_READ_RP, 8'h00);
      expect_v(S_RD, d);
    end
    cmd(fcr_pkg::OP_SET_RP_PERSIST, 8'h5A);
    expect_v(S_RP, d);
    write_enable_cmd();
    cmd(fcr_pkg::OP_SET_RP_PERSIST, 8'hA5);
    expect_v(S_RP, d);
    cmd(fcr_pkg::OP_SET_RP_WORKING_A, 8'h00);
    for (int k = 0; k < 6; k++) begin
      @(posedge core_clk_in) read_kind_in <= fcr_pkg::fcr_read_kind_t'(k);
      // the decoded count is registered one edge after the kind changes
      @(posedge core_clk_in);
      expect_v(S_DUM, {4'h0, dflt_tab[k]});
    end
    cmd(fcr_pkg::OP_WRITE_FUNC, 8'h12);
    expect_v(S_FR, 8'h00);
    write_enable_cmd();
    cmd(fcr_pkg::OP_WRITE_FUNC, 8'h12);
    expect_v(S_FR, 8'h12);
    for (int r = 0; r < 5; r++) begin
      @(posedge core_clk_in);
      ir_row_in <= r[1:0];
      ir_prog_req_in <= (r < 4);
      expect_v(S_ALLOW, {7'h00, r != 0 && r < 4});
    end
    write_enable_cmd();
    cmd(fcr_pkg::OP_WRITE_FUNC, 8'h00);
    expect_v(S_FR, 8'h12);
    write_enable_cmd();
    cmd(fcr_pkg::OP_WRITE_FUNC, 8'hFF);
    expect_v(S_FR, 8'hF3);
    check({info_row_lock_out, 3'h0, protect_area_direction_out}, 8'hF1);
    cmd(fcr_pkg::OP_READ_FUNC, 8'h00);
    expect_v(S_RD, 8'hF3);
    host.half = 150ns;
    for (int m = 0; m < 8; m++) begin
      cmd(fcr_pkg::OP_SET_RP_WORKING_B, {m[0], 7'h00});
      @(posedge core_clk_in);
      quad_lines_enable_in <= m[1];
      qpi_mode_in <= m[2];
      @(posedge core_clk_in);
      e = {5'h00, !(m[1] | m[2]) && !m[0], !(m[1] | m[2]) && m[0], m[1] | m[2]};
      expect_v(S_PIN, e);
      @(posedge core_clk_in);
      quad_lines_enable_in <= 1'b0;
      qpi_mode_in <= 1'b0;
    end
    host.half = 62.5ns;
    for (int j = 0; j < 2; j++) begin
      @(posedge core_clk_in);
      program_busy_in <= (j == 0);
      erase_busy_in <= (j == 1);
      suspend_in <= 1'b1;
      @(posedge core_clk_in) suspend_in <= 1'b0;
      e = (j == 0) ? 8'hF7 : 8'hFB;
      expect_v(S_FR, e);
      write_enable_cmd();
      cmd(fcr_pkg::OP_WRITE_FUNC, 8'h00);
      expect_v(S_FR, e);
      @(posedge core_clk_in) resume_in <= 1'b1;
      @(posedge core_clk_in) resume_in <= 1'b0;
      expect_v(S_FR, 8'hF3);
    end
    @(posedge core_clk_in) resetn_in <= 1'b0;
    do_reset();
    give_verdict();
  end
endmodule

/* File: test/fcr_host_model.sv */
// host serial controller model driving the register pins in mode 0
`timescale 1ns/1ps
module fcr_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic si_out,
  input wire logic so_in
);
  realtime half = 62.5ns;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  // opcode then data, msb first; the second byte collects what the device shifts out
  task automatic xfer(input logic [7:0] op, input logic [7:0] dat, input logic full, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {op, dat};
    rd = 8'h00;
    cs_n_out = 1'b0;
    for (int i = 0; i < (full ? 16 : 8); i++) begin
      si_out = sh[15 - i];
      #(half);
      sclk_out = 1'b1;
      if (i >= 8) rd = {rd[6:0], so_in};
      #(half);
      sclk_out = 1'b0;
    end
    #(half);
    cs_n_out = 1'b1;
    // released data line shows the inverse so a stale bit cannot pass
    si_out = ~si_out;
    #(4 * half);
  endtask
endmodule
